// *** design/gpt_pkg.sv ***
// Shared constants and types for the three-mode timer channel
package gpt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_WIDTH = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h10;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_IOP_BIT = 3;
  localparam int CTRL_IE_BIT = 4;
  localparam int CTRL_RUN_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam logic [1:0] START_DELAY_CYC = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_PWM = 2'b01,
    MODE_CAP = 2'b10,
    MODE_EXT = 2'b11
  } gpt_mode_t;

  typedef struct packed {
    logic timer_run_bit;
    logic interrupt_enable_bit;
    logic irq_on_period_sel;
    logic pulse_pol;
    gpt_mode_t mode;
  } gpt_ctrl_t;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b000,
    TS_START = 3'b001,
    TS_PWM_ACT = 3'b010,
    TS_PWM_INACT = 3'b011,
    TS_CAP_WAIT = 3'b100,
    TS_CAP_PULSE = 3'b101,
    TS_CAP_GAP = 3'b110,
    TS_EXT = 3'b111
  } gpt_state_t;

endpackage

// *** design/gpt_timer.sv ***
// Three-mode timer channel with Avalon-MM register slave
// How it works
// R01: Mode 01 drives output pin with polarity
// R02: Mode 10 measures pulses of chosen polarity
// R03: Mode 11 uses input pin, polarity ignored
// R04: Software stops timer before changing mode
// R05: Software programs period above width
// R06: Bad width or period flags error, interrupt
// R07: Good settings load width, counting starts
// R08: Output period and width are doubled
// R09: Reload doubled inactive, then doubled width
// R10: Interrupt at width or period end
// R11: Software reads status, writes ones clear
// R12: Capture interrupt on period or width
// R13: Captured values valid when latch sets
// R14: Captures halve counts, matching output scaling
// R15: Period reads zero before first measurement (pcap_r is cleared at the first trailing edge, not at start)
// R16: Event mode counts rising edges only
// R17: Event period write-only, width unused
// R18: Start loads period into down counter
// R19: Each rising edge counts; expiry reloads period
// R20: Event expiry latches and raises interrupt
// R21: Software avoids count reads in event mode
// R22: Operation begins three cycles after run
// R23: No latch set while interrupts disabled
// R24: Capture all-ones stops, overflow, interrupt
// R25: Sticky flags cleared by writing one
// R26: Polarity set means active phase high
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module gpt_timer
  import gpt_pkg::*;
#(
  parameter int DW = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic timer_input_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  output logic timer_interrupt_line_o
);

  localparam int CW = DW + 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DW < 4 || DW > 32) begin : g_bad_dw
    $error("gpt_timer: DW must be 4 to 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gpt_ctrl_t ctrl_r, ctrl_nxt;
  gpt_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [DW-1:0] per_r, per_nxt;
  logic [DW-1:0] wid_r, wid_nxt;
  logic [DW-1:0] pcap_r, pcap_nxt;
  logic [DW-1:0] wcap_r, wcap_nxt;
  logic first_r, first_nxt;
  logic [1:0] dly_r, dly_nxt;
  logic in_prev_r, in_prev_nxt;
  logic irq_r, irq_nxt;
  logic ovf_r, ovf_nxt;
  logic err_r, err_nxt;
  logic pin_r, pin_nxt;
  logic pin_oe_r, pin_oe_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic lead, trail, rise;
  logic irq_evt, ovf_set, err_set, run_clr;
  logic [CW-1:0] cnt_p1;
  logic [31:0] ctrl_wd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    per_nxt = per_r;
    wid_nxt = wid_r;
    pcap_nxt = pcap_r;
    wcap_nxt = wcap_r;
    first_nxt = first_r;
    dly_nxt = dly_r;
    pin_nxt = pin_r;
    in_prev_nxt = timer_input_pin_i;
    irq_evt = 1'b0;
    ovf_set = 1'b0;
    err_set = 1'b0;
    run_clr = 1'b0;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    cnt_p1 = cnt_r + 1'b1;
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    ctrl_wd = merge(32'(ctrl_r), avs_writedata_i, wmask);

    // Edges relative to the selected active level; rise is a plain rising edge
    lead = (timer_input_pin_i == ctrl_r.pulse_pol) && (in_prev_r != ctrl_r.pulse_pol); // R02 R26
    trail = (timer_input_pin_i != ctrl_r.pulse_pol) && (in_prev_r == ctrl_r.pulse_pol);
    rise = timer_input_pin_i && !in_prev_r; // R16

    // Output enable only in pulse output mode
    pin_oe_nxt = (ctrl_r.mode == MODE_PWM); // R01 R03

    // Register read mux
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      OFS_CTRL: rd_mux = 32'(ctrl_r);
      OFS_STATUS: begin
        rd_mux[STAT_IRQ_BIT] = irq_r;
        rd_mux[STAT_OVF_BIT] = ovf_r;
        rd_mux[STAT_ERR_BIT] = err_r;
        rd_mux[STAT_BUSY_BIT] = (st_r != TS_IDLE);
      end
      OFS_PERIOD: begin
        if (ctrl_r.mode == MODE_CAP) begin
          rd_mux = 32'(pcap_r); // R15
        end else if (ctrl_r.mode != MODE_EXT) begin // R17
          rd_mux = 32'(per_r);
        end
      end
      OFS_WIDTH: rd_mux = (ctrl_r.mode == MODE_CAP) ? 32'(wcap_r) : 32'(wid_r);
      OFS_COUNT: rd_mux = 32'(cnt_r[DW-1:0]);
      default: rd_mux = 32'h0000_0000;
    endcase

    // Avalon handshake: one wait cycle, then the access completes
    if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = avs_read_i ? rd_mux : rdata_r;
    end
    wr_acc = avs_write_i && !wait_r;

    // Timer sequencing
    case (st_r)
      TS_IDLE: st_nxt = TS_IDLE;
      TS_START: begin
        if (dly_r != 2'h0) begin
          dly_nxt = dly_r - 2'h1; // R22
        end else begin
          case (ctrl_r.mode)
            MODE_PWM: begin
              if (wid_r == '0 || per_r <= wid_r) begin // R06
                err_set = 1'b1;
                irq_evt = 1'b1;
                run_clr = 1'b1;
                st_nxt = TS_IDLE;
              end else begin
                cnt_nxt = {wid_r, 1'b0}; // R07 R08
                pin_nxt = ctrl_r.pulse_pol; // R26
                st_nxt = TS_PWM_ACT;
              end
            end
            MODE_CAP: begin
              cnt_nxt = '0;
              first_nxt = 1'b1;
              st_nxt = TS_CAP_WAIT;
            end
            MODE_EXT: begin
              cnt_nxt = CW'(per_r); // R18
              st_nxt = TS_EXT;
            end
            default: st_nxt = TS_IDLE;
          endcase
        end
      end
      TS_PWM_ACT: begin
        if (cnt_r <= CW'(1)) begin
          cnt_nxt = {per_r - wid_r, 1'b0}; // R09
          pin_nxt = !ctrl_r.pulse_pol;
          irq_evt = !ctrl_r.irq_on_period_sel; // R10
          st_nxt = TS_PWM_INACT;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      TS_PWM_INACT: begin
        if (cnt_r <= CW'(1)) begin
          cnt_nxt = {wid_r, 1'b0}; // R09
          pin_nxt = ctrl_r.pulse_pol;
          irq_evt = ctrl_r.irq_on_period_sel; // R10
          st_nxt = TS_PWM_ACT;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      TS_CAP_WAIT: begin
        if (lead) begin
          cnt_nxt = '0;
          st_nxt = TS_CAP_PULSE;
        end
      end
      TS_CAP_PULSE, TS_CAP_GAP: begin
        cnt_nxt = cnt_p1;
        if (cnt_r == '1) begin // R24
          ovf_set = 1'b1;
          irq_evt = 1'b1;
          run_clr = 1'b1;
          st_nxt = TS_IDLE;
        end else if (st_r == TS_CAP_PULSE && trail) begin
          wcap_nxt = cnt_p1[CW-1:1]; // R14
          pcap_nxt = first_r ? '0 : pcap_r; // R15
          irq_evt = !ctrl_r.irq_on_period_sel; // R12 R13
          st_nxt = TS_CAP_GAP;
        end else if (st_r == TS_CAP_GAP && lead) begin
          pcap_nxt = cnt_p1[CW-1:1]; // R14
          first_nxt = 1'b0;
          cnt_nxt = '0;
          irq_evt = ctrl_r.irq_on_period_sel; // R12 R13
          st_nxt = TS_CAP_PULSE;
        end
      end
      TS_EXT: begin
        if (rise) begin // R19
          if (cnt_r <= CW'(1)) begin
            cnt_nxt = CW'(per_r);
            irq_evt = 1'b1; // R20
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      end
      default: st_nxt = TS_IDLE;
    endcase

    ctrl_nxt.timer_run_bit = ctrl_r.timer_run_bit & !run_clr; // R24

    // Software writes
    if (wr_acc && avs_address_i == OFS_CTRL) begin
      ctrl_nxt = gpt_ctrl_t'(ctrl_wd[5:0]);
      if (!ctrl_wd[CTRL_RUN_BIT]) begin
        st_nxt = TS_IDLE;
      end else if (!ctrl_r.timer_run_bit) begin
        st_nxt = TS_START;
        dly_nxt = START_DELAY_CYC - 2'h1; // R22
      end
    end
    if (wr_acc && avs_address_i == OFS_PERIOD && ctrl_r.mode != MODE_CAP) begin
      per_nxt = DW'(merge(32'(per_r), avs_writedata_i, wmask));
    end
    if (wr_acc && avs_address_i == OFS_WIDTH && ctrl_r.mode != MODE_CAP) begin
      wid_nxt = DW'(merge(32'(wid_r), avs_writedata_i, wmask));
    end

    // Sticky flags: a new event wins over a same-cycle clear
    irq_nxt = irq_r;
    ovf_nxt = ovf_r;
    err_nxt = err_r;
    if (wr_acc && avs_address_i == OFS_STATUS && avs_byteenable_i[0]) begin
      irq_nxt = irq_r & !avs_writedata_i[STAT_IRQ_BIT]; // R25
      ovf_nxt = ovf_r & !avs_writedata_i[STAT_OVF_BIT]; // R25
      err_nxt = err_r & !avs_writedata_i[STAT_ERR_BIT]; // R25
    end
    irq_nxt = irq_nxt | (irq_evt & ctrl_r.interrupt_enable_bit); // R23
    ovf_nxt = ovf_nxt | ovf_set;
    err_nxt = err_nxt | err_set;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= gpt_ctrl_t'(CTRL_RST);
      st_r <= TS_IDLE;
      cnt_r <= '0;
      per_r <= '0;
      wid_r <= '0;
      pcap_r <= '0;
      wcap_r <= '0;
      first_r <= 1'b1;
      dly_r <= 2'h0;
      in_prev_r <= 1'b0;
      irq_r <= 1'b0;
      ovf_r <= 1'b0;
      err_r <= 1'b0;
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      wid_r <= wid_nxt;
      pcap_r <= pcap_nxt;
      wcap_r <= wcap_nxt;
      first_r <= first_nxt;
      dly_r <= dly_nxt;
      in_prev_r <= in_prev_nxt;
      irq_r <= irq_nxt;
      ovf_r <= ovf_nxt;
      err_r <= err_nxt;
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Interrupt line follows the latch so an idle core can be woken
  assign timer_interrupt_line_o = irq_r; // R20
  assign timer_output_pin_o = pin_r; // R01
  assign timer_output_pin_oe_o = pin_oe_r;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

endmodule

`default_nettype wire

// *** verification/gpt_timer_asserts.sv ***
// Bus and timer checks for the timer channel
`timescale 1ns/1ps
`default_nettype none

module gpt_timer_asrt
  import gpt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic timer_input_pin_i,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_oe_o,
  input wire logic timer_interrupt_line_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  logic done, cw, sc, ie_r, ie_nxt;
  assign done = !avs_waitrequest_o;
  assign cw = avs_write_i && done && avs_address_i == OFS_CTRL && avs_byteenable_i[0];
  assign sc = avs_write_i && done && avs_address_i == OFS_STATUS && avs_byteenable_i[0]
    && avs_writedata_i[STAT_IRQ_BIT];

  // Shadow of the enable bit, as the design should hold it
  always_comb begin
    ie_nxt = ie_r;
    if (cw) begin
      ie_nxt = avs_writedata_i[CTRL_IE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ie_r <= 1'b0;
    end else begin
      ie_r <= ie_nxt;
    end
  end

  a_wait_one: assert property (done |=> !done)
    else $error("waitrequest low twice");
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && !done |=> done)
    else $error("no answer in one cycle");
  a_oe_on: assert property (cw && avs_writedata_i[1:0] == MODE_PWM
    |-> ##2 timer_output_pin_oe_o)
    else $error("enable missing in pulse mode");
  a_oe_off: assert property (cw && avs_writedata_i[1:0] != MODE_PWM
    |-> ##2 !timer_output_pin_oe_o)
    else $error("enable high outside pulse mode");
  a_pin_hold: assert property (!timer_output_pin_oe_o [*2] |-> $stable(timer_output_pin_o))
    else $error("pin moved while not driven");
  a_irq_needs_ie: assert property ($rose(timer_interrupt_line_o) |-> $past(ie_r))
    else $error("latch set with interrupts off");
  a_irq_sticky: assert property (timer_interrupt_line_o && !sc |=> timer_interrupt_line_o)
    else $error("latch dropped without clear");
  a_rd_unmapped: assert property (avs_read_i && done && avs_address_i > OFS_COUNT
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

bind gpt_timer gpt_timer_asrt gpt_timer_asrt_inst (
  .clk_sys_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .timer_input_pin_i,
  .timer_output_pin_o, .timer_output_pin_oe_o, .timer_interrupt_line_o
);

`default_nettype wire

// *** verification/gpt_wave_src.sv ***
// Pulse source standing in for the equipment on the timer input pin
`timescale 1ns/1ps
`default_nettype none

module gpt_wave_src (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic pol_i,
  input wire logic [7:0] act_i,
  input wire logic [7:0] idle_i,
  output logic pin_o
);
  logic act_r;
  logic [7:0] cnt_r;

  // Phase freezes while stopped, so a stall holds the level
  assign pin_o = act_r ? pol_i : !pol_i;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_r <= 1'b0;
      cnt_r <= 8'h01;
    end else if (run_i) begin
      if (cnt_r <= 8'h01) begin
        act_r <= !act_r;
        cnt_r <= act_r ? idle_i : act_i;
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none

module tb;
  import gpt_pkg::*;

  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, q;
  logic [31:0] cur = 32'h0000_0000;
  logic avs_waitrequest_o, timer_input_pin_i, timer_output_pin_o;
  logic timer_output_pin_oe_o, timer_interrupt_line_o;
  logic src_run = 1'b0;
  logic src_pol = 1'b1;
  int err_total = 0;
  int total_checks = 0;
  int rises = 0;
  int n;
  int ew[3] = '{0, 3, 4};
  int ep[3] = '{5, 3, 2};

  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge timer_input_pin_i) rises++;

  gpt_timer #(.DW(8)) gpt_timer_inst (
    .clk_sys_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .timer_input_pin_i,
    .timer_output_pin_o, .timer_output_pin_oe_o, .timer_interrupt_line_o
  );

  // Width 3, period 7 as seen by a capturing channel
  gpt_wave_src gpt_wave_src_inst (
    .clk_sys_i, .rst_b_i, .run_i(src_run), .pol_i(src_pol),
    .act_i(8'h06), .idle_i(8'h08), .pin_o(timer_input_pin_i)
  );

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0000_0000);
    chk(s, e, q);
  endtask

  task automatic tk();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wpin(input logic v);
    n = 0;
    while (timer_output_pin_o !== v) begin
      tk();
      n++;
    end
  endtask

  task automatic wirq();
    do tk(); while (timer_interrupt_line_o !== 1'b1);
  endtask

  task automatic go(gpt_mode_t m, logic p, logic i, logic e, logic [31:0] w, logic [31:0] pd);
    bus(1'b1, OFS_CTRL, cur & 32'hffff_ffdf);
    bus(1'b1, OFS_STATUS, 32'h0000_0007);
    cur = {26'h000_0000, gpt_ctrl_t'{1'b0, e, i, p, m}};
    bus(1'b1, OFS_CTRL, cur);
    bus(1'b1, OFS_WIDTH, w);
    bus(1'b1, OFS_PERIOD, pd);
    cur[CTRL_RUN_BIT] = 1'b1;
    bus(1'b1, OFS_CTRL, cur);
  endtask

  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdc(OFS_CTRL, 32'h0000_0000, "ctrl_rst");
    rdc(OFS_STATUS, 32'h0000_0000, "stat_rst");
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    rdc(5'h1c, 32'h0000_0000, "unmapped");
    for (int k = 0; k < 2; k++) begin
      go(MODE_PWM, !k, 1'b0, 1'b0, 2, 5);
      wpin(!k);
      if (k == 0) chk("start", 3, n);
      chk("oe", 1, timer_output_pin_oe_o);
      wpin(k);
      wpin(!k);
      wpin(k);
      chk("act", 4, n);
      wpin(!k);
      chk("idle", 6, n);
    end
    for (int i = 0; i < 2; i++) begin
      go(MODE_PWM, 1'b1, i[0], 1'b1, 2, 5);
      wirq();
      chk("irq_phase", i, timer_output_pin_o);
    end
    // Bad settings: zero width, equal, inverted
    for (int j = 0; j < 3; j++) begin
      go(MODE_PWM, 1'b1, 1'b0, j != 1, ew[j], ep[j]);
      repeat (4) tk();
      rdc(OFS_STATUS, 32'h0000_0004 | (j != 1), "err");
      rdc(OFS_CTRL, cur & 32'hffff_ffdf, "err_stop");
    end
    src_run <= 1'b1;
    go(MODE_CAP, 1'b1, 1'b0, 1'b1, 0, 0);
    wirq();
    rdc(OFS_WIDTH, 3, "cap_w");
    rdc(OFS_PERIOD, 0, "cap_p0");
    bus(1'b1, OFS_STATUS, 32'h0000_0001);
    wirq();
    rdc(OFS_PERIOD, 7, "cap_p");
    src_pol <= 1'b0;
    go(MODE_CAP, 1'b0, 1'b1, 1'b1, 0, 0);
    wirq();
    rdc(OFS_PERIOD, 7, "iop_p");
    rdc(OFS_WIDTH, 3, "iop_w");
    // Stalled source: counter runs into all ones
    src_run <= 1'b0;
    do bus(1'b0, OFS_STATUS, 32'h0000_0000); while (q[STAT_OVF_BIT] !== 1'b1);
    chk("ovf", 3, q);
    rdc(OFS_CTRL, cur & 32'hffff_ffdf, "ovf_stop");
    bus(1'b1, OFS_STATUS, 32'h0000_0002);
    rdc(OFS_STATUS, 1, "sticky");
    go(MODE_EXT, 1'b0, 1'b0, 1'b1, 0, 3);
    rdc(OFS_PERIOD, 0, "prd_wo");
    chk("oe_off", 0, timer_output_pin_oe_o);
    rises = 0;
    src_run <= 1'b1;
    wirq();
    chk("ev1", 3, rises);
    bus(1'b1, OFS_STATUS, 32'h0000_0001);
    wirq();
    chk("ev2", 6, rises);
    finish_test();
  end

  initial begin
    #80000;
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
